// ===== hw/rtcta_regs.svh
// Register offsets, field positions, masks and reset values of the RTC timestamp/calibration/alarm unit
`ifndef RTCTA_REGS_SVH
`define RTCTA_REGS_SVH

// Word addresses on the register port
`define RTCTA_A_CTRL      4'h0
`define RTCTA_A_ALM_CTRL  4'h1
`define RTCTA_A_DIV       4'h2
`define RTCTA_A_FINE_PRESCALE      4'h3
`define RTCTA_A_TS_TL     4'h4
`define RTCTA_A_TS_TH     4'h5
`define RTCTA_A_TS_DL     4'h6
`define RTCTA_A_TS_DH     4'h7
`define RTCTA_A_AV_TL     4'h8
`define RTCTA_A_AV_TH     4'h9
`define RTCTA_A_AV_DL     4'ha
`define RTCTA_A_AV_DH     4'hb
`define RTCTA_A_TS_BASE   2'h1
`define RTCTA_A_AV_BASE   2'h2

// Word index inside a timestamp or alarm group
`define RTCTA_W_TL        2'h0
`define RTCTA_W_TH        2'h1
`define RTCTA_W_DL        2'h2
`define RTCTA_W_DH        2'h3

// Field positions
`define RTCTA_B_CAP_EN    0
`define RTCTA_B_CAP_FLAG  1
`define RTCTA_B_ALM_EN    15
`define RTCTA_B_CHIME     14
`define RTCTA_ALARM_DIGIT_MASK_HI    11
`define RTCTA_ALARM_DIGIT_MASK_LO    8
`define RTCTA_RPT_HI      7
`define RTCTA_RPT_LO      0
`define RTCTA_FINE_PRESCALE_HI     4

// Implemented bits of each time/date word
`define RTCTA_MSK_TL      16'h7f00
`define RTCTA_MSK_TH      16'h3f7f
`define RTCTA_MSK_DL      16'h3f07
`define RTCTA_MSK_DH      16'hff1f
`define RTCTA_MSK_ALL     16'hffff
`define RTCTA_MSK_NONE    16'h0000

// Digit groups used by the alarm comparison
`define RTCTA_F_SEC_U     16'h0f00
`define RTCTA_F_SEC       16'h7f00
`define RTCTA_F_MIN_U     16'h000f
`define RTCTA_F_MIN       16'h007f
`define RTCTA_F_HRMIN     16'h3f7f
`define RTCTA_F_WEEKDAY_DIGIT      16'h0007
`define RTCTA_F_DAY       16'h3f00
`define RTCTA_F_MONTH     16'h001f

// Alarm interval codes
`define RTCTA_AM_HALF     4'h0
`define RTCTA_AM_SEC      4'h1
`define RTCTA_AM_10SEC    4'h2
`define RTCTA_AM_MIN      4'h3
`define RTCTA_AM_10MIN    4'h4
`define RTCTA_AM_HOUR     4'h5
`define RTCTA_AM_DAY      4'h6
`define RTCTA_AM_WEEK     4'h7
`define RTCTA_AM_MONTH    4'h8
`define RTCTA_AM_YEAR     4'h9

// Reset and limit values
`define RTCTA_RST_DIV     16'hffff
`define RTCTA_RST_FINE_PRESCALE    5'h1f
`define RTCTA_ZERO16      16'h0000
`define RTCTA_RPT_MAX     8'hff
`define RTCTA_RPT_ZERO    8'h00
`define RTCTA_RPT_ONE     8'h01
`define RTCTA_PS_ZERO     21'h000000
`define RTCTA_PS_ONE      21'h000001

`endif

// ===== hw/rtcta_pkg.sv
// Types shared by the RTC timestamp/calibration/alarm unit
package rtcta_pkg;

  typedef struct packed {
    logic [3:0] year_tens;
    logic [3:0] year_units;
    logic [0:0] month_tens;
    logic [3:0] month_units;
    logic [1:0] day_tens;
    logic [3:0] day_units;
    logic [2:0] weekday_digit;
    logic [1:0] hours_tens;
    logic [3:0] hours_units;
    logic [2:0] minutes_tens;
    logic [3:0] minutes_units;
    logic [2:0] seconds_tens;
    logic [3:0] seconds_units;
  } rtcta_time_t;

  typedef enum logic {CAP_IDLE, CAP_BUSY} rtcta_cap_state_t;

endpackage : rtcta_pkg

// ===== hw/rtcta_ts_mem.sv
// Four-word timestamp store, kept through soft resets, with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "rtcta_regs.svh"

module rtcta_ts_mem (
  // Clock, power-on reset and clock enable
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // Write port
  input  wire logic        we_in,
  input  wire logic [1:0]  waddr_in,
  input  wire logic [15:0] wdata_in,
  // Read port
  input  wire logic        re_in,
  input  wire logic [1:0]  raddr_in,
  output logic      [15:0] rdata_out
);

  logic [15:0] mem_r [4];

  // Only power-on reset clears the store
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 4; i++) begin
        mem_r[i] <= `RTCTA_ZERO16;
      end
    end else if (ce_in && we_in) begin
      mem_r[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= `RTCTA_ZERO16;
    end else if (ce_in && re_in) begin
      rdata_out <= mem_r[raddr_in];
    end
  end

endmodule : rtcta_ts_mem
`default_nettype wire

// ===== hw/rtcta_top.sv
// RTC timestamp store, calibrated one-second prescaler and repeating alarm
`timescale 1ns/10ps
`default_nettype none
`include "rtcta_regs.svh"

module rtcta_top (
  // Clock, resets, clock enable
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 soft_rst_in,
  input  wire logic                 ce_in,
  // Register port
  input  wire logic [3:0]           addr_in,
  input  wire logic [15:0]          wr_data_in,
  input  wire logic                 wr_in,
  input  wire logic                 rd_in,
  output logic      [15:0]          rd_data_out,
  // Running clock value and capture event
  input  wire rtcta_pkg::rtcta_time_t cur_time_in,
  input  wire logic                 capture_event_in,
  // Tick and alarm outputs
  output logic                      tick_out,
  output logic                      half_tick_out,
  output logic                      alarm_irq_out
);

  // Pack a time value into one of the four register words
  function automatic logic [15:0] ts_word(input rtcta_pkg::rtcta_time_t t, input logic [1:0] idx);
    logic [15:0] w;
    w = `RTCTA_ZERO16;
    case (idx)
      `RTCTA_W_TL: w = {1'b0, t.seconds_tens, t.seconds_units, 8'h00};
      `RTCTA_W_TH: w = {2'b00, t.hours_tens, t.hours_units, 1'b0, t.minutes_tens, t.minutes_units};
      `RTCTA_W_DL: w = {2'b00, t.day_tens, t.day_units, 5'h00, t.weekday_digit};
      default:     w = {t.year_tens, t.year_units, 3'h0, t.month_tens, t.month_units};
    endcase
    return w;
  endfunction : ts_word

  // Implemented bits of each word
  function automatic logic [15:0] word_mask(input logic [1:0] idx);
    logic [15:0] m;
    m = `RTCTA_MSK_NONE;
    case (idx)
      `RTCTA_W_TL: m = `RTCTA_MSK_TL;
      `RTCTA_W_TH: m = `RTCTA_MSK_TH;
      `RTCTA_W_DL: m = `RTCTA_MSK_DL;
      default:     m = `RTCTA_MSK_DH;
    endcase
    return m;
  endfunction : word_mask

  // Digits compared per interval code, as {date_high, date_low, time_high, time_low}
  function automatic logic [63:0] interval_mask(input logic [3:0] code);
    logic [63:0] m;
    m = {`RTCTA_MSK_NONE, `RTCTA_MSK_NONE, `RTCTA_MSK_NONE, `RTCTA_MSK_NONE};
    case (code)
      `RTCTA_AM_10SEC: m[15:0] = `RTCTA_F_SEC_U;
      `RTCTA_AM_MIN:   m[15:0] = `RTCTA_F_SEC;
      `RTCTA_AM_10MIN: m[31:0] = {`RTCTA_F_MIN_U, `RTCTA_F_SEC};
      `RTCTA_AM_HOUR:  m[31:0] = {`RTCTA_F_MIN, `RTCTA_F_SEC};
      `RTCTA_AM_DAY:   m[31:0] = {`RTCTA_F_HRMIN, `RTCTA_F_SEC};
      `RTCTA_AM_WEEK:  m[47:0] = {`RTCTA_F_WEEKDAY_DIGIT, `RTCTA_F_HRMIN, `RTCTA_F_SEC};
      `RTCTA_AM_MONTH: m[47:0] = {`RTCTA_F_DAY, `RTCTA_F_HRMIN, `RTCTA_F_SEC};
      `RTCTA_AM_YEAR:  m = {`RTCTA_F_MONTH, `RTCTA_F_DAY, `RTCTA_F_HRMIN, `RTCTA_F_SEC};
      default:         m = {`RTCTA_MSK_NONE, `RTCTA_MSK_NONE, `RTCTA_MSK_NONE, `RTCTA_MSK_NONE};
    endcase
    return m;
  endfunction : interval_mask

  // Codes above the year interval never fire
  function automatic logic code_valid(input logic [3:0] code);
    return code <= `RTCTA_AM_YEAR;
  endfunction : code_valid

  // Register group decode
  function automatic logic in_group(input logic [3:0] a, input logic [1:0] grp);
    return a[3:2] == grp;
  endfunction : in_group

  // Control and calibration state
  logic                         cap_en_r;
  logic                         cap_flag_r;
  logic [15:0]                  div_r;
  logic [4:0]                   fine_prescale_r;
  logic [20:0]                  ps_cnt_r;
  logic [20:0]                  presc;
  logic                         ps_wrap;
  // Alarm state
  logic                         alm_en_r;
  logic                         chime_r;
  logic [3:0]                   alarm_digit_mask_r;
  logic [7:0]                   rpt_r;
  logic [15:0]                  av_r [4];
  logic [63:0]                  cur_words;
  logic [63:0]                  av_words;
  logic                         alm_match;
  logic                         alm_evt;
  logic                         fire;
  // Capture and register port
  rtcta_pkg::rtcta_cap_state_t  cap_state_r;
  rtcta_pkg::rtcta_time_t       snap_r;
  logic [1:0]                   cap_ptr_r;
  logic                         cap_start;
  logic                         cap_done;
  logic                         wr_ctrl;
  logic                         wr_actl;
  logic                         mem_we;
  logic [15:0]                  mem_wdata;
  logic [1:0]                   mem_waddr;
  logic [15:0]                  mem_q;
  logic [15:0]                  rd_r;
  logic [15:0]                  rd_mask_r;
  logic                         rd_ts_r;

  assign wr_ctrl = wr_in && (addr_in == `RTCTA_A_CTRL);
  assign wr_actl = wr_in && (addr_in == `RTCTA_A_ALM_CTRL);

  // Prescaler: period is the 21-bit value plus one clock
  assign presc   = {div_r, fine_prescale_r};
  assign ps_wrap = ps_cnt_r >= presc;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_r  <= `RTCTA_RST_DIV;
      fine_prescale_r <= `RTCTA_RST_FINE_PRESCALE;
    end else if (ce_in) begin
      if (soft_rst_in) begin
        div_r  <= `RTCTA_RST_DIV;
        fine_prescale_r <= `RTCTA_RST_FINE_PRESCALE;
      end else if (wr_in && addr_in == `RTCTA_A_DIV) begin
        div_r <= wr_data_in;
      end else if (wr_in && addr_in == `RTCTA_A_FINE_PRESCALE) begin
        fine_prescale_r <= wr_data_in[`RTCTA_FINE_PRESCALE_HI:0];
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ps_cnt_r      <= `RTCTA_PS_ZERO;
      tick_out      <= 1'b0;
      half_tick_out <= 1'b0;
    end else if (ce_in) begin
      if (soft_rst_in) begin
        ps_cnt_r      <= `RTCTA_PS_ZERO;
        tick_out      <= 1'b0;
        half_tick_out <= 1'b0;
      end else begin
        ps_cnt_r      <= ps_wrap ? `RTCTA_PS_ZERO : ps_cnt_r + `RTCTA_PS_ONE;
        tick_out      <= ps_wrap;
        half_tick_out <= ps_wrap || (ps_cnt_r == (presc >> 1));
      end
    end
  end

  // Alarm comparison against the running clock, once per tick, or on every half tick for the half-second code
  always_comb begin
    cur_words = {ts_word(cur_time_in, `RTCTA_W_DH), ts_word(cur_time_in, `RTCTA_W_DL),
                 ts_word(cur_time_in, `RTCTA_W_TH), ts_word(cur_time_in, `RTCTA_W_TL)};
    av_words  = {av_r[3], av_r[2], av_r[1], av_r[0]};
  end

  assign alm_match = code_valid(alarm_digit_mask_r) && (((cur_words ^ av_words) & interval_mask(alarm_digit_mask_r)) == 64'h0);
  assign alm_evt   = (alarm_digit_mask_r == `RTCTA_AM_HALF) ? half_tick_out : tick_out;
  assign fire      = ce_in && !soft_rst_in && alm_en_r && alm_evt && alm_match;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      alarm_irq_out <= 1'b0;
    end else if (ce_in) begin
      alarm_irq_out <= fire;
    end
  end

  // Alarm control: software write wins over the sequencing of the same cycle
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      alm_en_r <= 1'b0;
      chime_r  <= 1'b0;
      alarm_digit_mask_r  <= `RTCTA_AM_HALF;
      rpt_r    <= `RTCTA_RPT_ZERO;
    end else if (ce_in) begin
      if (soft_rst_in) begin
        alm_en_r <= 1'b0;
        chime_r  <= 1'b0;
        alarm_digit_mask_r  <= `RTCTA_AM_HALF;
        rpt_r    <= `RTCTA_RPT_ZERO;
      end else if (wr_actl) begin
        alm_en_r <= wr_data_in[`RTCTA_B_ALM_EN];
        chime_r  <= wr_data_in[`RTCTA_B_CHIME];
        alarm_digit_mask_r  <= wr_data_in[`RTCTA_ALARM_DIGIT_MASK_HI:`RTCTA_ALARM_DIGIT_MASK_LO];
        rpt_r    <= wr_data_in[`RTCTA_RPT_HI:`RTCTA_RPT_LO];
      end else if (fire) begin
        if (rpt_r != `RTCTA_RPT_ZERO) begin
          rpt_r <= rpt_r - `RTCTA_RPT_ONE;
        end else if (chime_r) begin
          rpt_r <= `RTCTA_RPT_MAX;
        end else begin
          alm_en_r <= 1'b0;
        end
      end
    end
  end

  // Alarm compare value; only meaningful to change while the alarm is disabled
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 4; i++) begin
        av_r[i] <= `RTCTA_ZERO16;
      end
    end else if (ce_in) begin
      if (soft_rst_in) begin
        for (int i = 0; i < 4; i++) begin
          av_r[i] <= `RTCTA_ZERO16;
        end
      end else if (wr_in && in_group(addr_in, `RTCTA_A_AV_BASE)) begin
        av_r[addr_in[1:0]] <= wr_data_in & word_mask(addr_in[1:0]);
      end
    end
  end

  // Timestamp capture: hardware event or a one written to the flag with capture enabled
  assign cap_start = ce_in && !soft_rst_in && cap_en_r && !cap_flag_r && (cap_state_r == rtcta_pkg::CAP_IDLE) &&
                     (capture_event_in || (wr_ctrl && wr_data_in[`RTCTA_B_CAP_FLAG]));
  assign cap_done  = (cap_state_r == rtcta_pkg::CAP_BUSY) && (cap_ptr_r == `RTCTA_W_DH);

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cap_state_r <= rtcta_pkg::CAP_IDLE;
      cap_ptr_r   <= `RTCTA_W_TL;
      snap_r      <= '0;
    end else if (ce_in) begin
      if (soft_rst_in) begin
        cap_state_r <= rtcta_pkg::CAP_IDLE;
        cap_ptr_r   <= `RTCTA_W_TL;
      end else begin
        case (cap_state_r)
          rtcta_pkg::CAP_IDLE: begin
            cap_ptr_r <= `RTCTA_W_TL;
            if (cap_start) begin
              snap_r      <= cur_time_in;
              cap_state_r <= rtcta_pkg::CAP_BUSY;
            end
          end
          rtcta_pkg::CAP_BUSY: begin
            cap_ptr_r <= cap_ptr_r + 2'h1;
            if (cap_done) begin
              cap_state_r <= rtcta_pkg::CAP_IDLE;
            end
          end
          default: cap_state_r <= rtcta_pkg::CAP_IDLE;
        endcase
      end
    end
  end

  // Capture control; completion sets the flag even against a clearing write
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cap_en_r   <= 1'b0;
      cap_flag_r <= 1'b0;
    end else if (ce_in) begin
      if (soft_rst_in) begin
        cap_en_r   <= 1'b0;
        cap_flag_r <= 1'b0;
      end else begin
        if (wr_ctrl) begin
          cap_en_r <= wr_data_in[`RTCTA_B_CAP_EN];
        end
        if (cap_done) begin
          cap_flag_r <= 1'b1;
        end else if (wr_ctrl && !wr_data_in[`RTCTA_B_CAP_FLAG]) begin
          cap_flag_r <= 1'b0;
        end
      end
    end
  end

  // Store write: capture has priority over a software write
  assign mem_we    = (cap_state_r == rtcta_pkg::CAP_BUSY) || (wr_in && in_group(addr_in, `RTCTA_A_TS_BASE));
  assign mem_waddr = (cap_state_r == rtcta_pkg::CAP_BUSY) ? cap_ptr_r : addr_in[1:0];
  assign mem_wdata = (cap_state_r == rtcta_pkg::CAP_BUSY) ? ts_word(snap_r, cap_ptr_r) :
                     (wr_data_in & (cap_en_r ? word_mask(addr_in[1:0]) : `RTCTA_MSK_ALL));

  rtcta_ts_mem u_ts_mem (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .we_in      (mem_we),
    .waddr_in   (mem_waddr),
    .wdata_in   (mem_wdata),
    .re_in      (rd_in),
    .raddr_in   (addr_in[1:0]),
    .rdata_out  (mem_q)
  );

  // Read path: data stand only in the cycle after the read strobe
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_r      <= `RTCTA_ZERO16;
      rd_ts_r   <= 1'b0;
      rd_mask_r <= `RTCTA_MSK_ALL;
    end else if (ce_in) begin
      rd_ts_r   <= rd_in && in_group(addr_in, `RTCTA_A_TS_BASE);
      rd_mask_r <= cap_en_r ? word_mask(addr_in[1:0]) : `RTCTA_MSK_ALL;
      rd_r      <= `RTCTA_ZERO16;
      if (rd_in) begin
        case (addr_in)
          `RTCTA_A_CTRL:     rd_r <= {14'h0000, cap_flag_r, cap_en_r};
          `RTCTA_A_ALM_CTRL: rd_r <= {alm_en_r, chime_r, 2'b00, alarm_digit_mask_r, rpt_r};
          `RTCTA_A_DIV:      rd_r <= div_r;
          `RTCTA_A_FINE_PRESCALE:     rd_r <= {11'h000, fine_prescale_r};
          `RTCTA_A_AV_TL:    rd_r <= av_r[0];
          `RTCTA_A_AV_TH:    rd_r <= av_r[1];
          `RTCTA_A_AV_DL:    rd_r <= av_r[2];
          `RTCTA_A_AV_DH:    rd_r <= av_r[3];
          default:           rd_r <= `RTCTA_ZERO16;
        endcase
      end
    end
  end

  assign rd_data_out = rd_ts_r ? (mem_q & rd_mask_r) : rd_r;

  // Checks
  property p_rpt_dec;
    @(posedge sys_clk_in) disable iff (rst_in)
    fire && !wr_actl && rpt_r != `RTCTA_RPT_ZERO |=> rpt_r == $past(rpt_r) - `RTCTA_RPT_ONE && alm_en_r;
  endproperty
  a_rpt_dec: assert property (p_rpt_dec) else $error("repeat count not decremented");

  property p_final_off;
    @(posedge sys_clk_in) disable iff (rst_in)
    fire && !wr_actl && rpt_r == `RTCTA_RPT_ZERO && !chime_r |=> !alm_en_r ##1 !fire;
  endproperty
  a_final_off: assert property (p_final_off) else $error("alarm still enabled after final alarm");

  property p_chime_wrap;
    @(posedge sys_clk_in) disable iff (rst_in)
    fire && !wr_actl && rpt_r == `RTCTA_RPT_ZERO && chime_r |=> alm_en_r && rpt_r == `RTCTA_RPT_MAX;
  endproperty
  a_chime_wrap: assert property (p_chime_wrap) else $error("chime did not wrap count");

  property p_irq;
    @(posedge sys_clk_in) disable iff (rst_in)
    fire |=> alarm_irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("alarm interrupt missing");

  property p_irq_cause;
    @(posedge sys_clk_in) disable iff (rst_in)
    $rose(alarm_irq_out) |-> $past(alm_en_r) && $past(alm_match) && $past(alm_evt);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("alarm without enable and match");

  property p_tick;
    @(posedge sys_clk_in) disable iff (rst_in || soft_rst_in)
    ce_in && ps_cnt_r == presc |=> tick_out && ps_cnt_r == `RTCTA_PS_ZERO;
  endproperty
  a_tick: assert property (p_tick) else $error("prescaler did not wrap at divide value");

  property p_capture;
    @(posedge sys_clk_in) disable iff (rst_in || soft_rst_in)
    (cap_start ##1 ce_in [*4]) |=> cap_flag_r && cap_state_r == rtcta_pkg::CAP_IDLE;
  endproperty
  a_capture: assert property (p_capture) else $error("capture did not complete in four cycles");

  property p_ts_th_bits;
    @(posedge sys_clk_in) disable iff (rst_in)
    ce_in && rd_in && addr_in == `RTCTA_A_TS_TH && cap_en_r |=> (rd_data_out & ~`RTCTA_MSK_TH) == `RTCTA_ZERO16;
  endproperty
  a_ts_th_bits: assert property (p_ts_th_bits) else $error("unimplemented time bits read nonzero");

  property p_ts_dl_bits;
    @(posedge sys_clk_in) disable iff (rst_in)
    ce_in && rd_in && addr_in == `RTCTA_A_TS_DL && cap_en_r |=> (rd_data_out & ~`RTCTA_MSK_DL) == `RTCTA_ZERO16;
  endproperty
  a_ts_dl_bits: assert property (p_ts_dl_bits) else $error("unimplemented date bits read nonzero");

  c_alarm: cover property (@(posedge sys_clk_in) disable iff (rst_in) fire);
  c_final: cover property (@(posedge sys_clk_in) disable iff (rst_in) fire && rpt_r == `RTCTA_RPT_ZERO && !chime_r);
  c_wrap: cover property (@(posedge sys_clk_in) disable iff (rst_in) fire && rpt_r == `RTCTA_RPT_ZERO && chime_r);
  c_capture: cover property (@(posedge sys_clk_in) disable iff (rst_in) cap_done);

endmodule : rtcta_top
`default_nettype wire

// ===== testbench/rtcta_top_tb.sv
// Self-checking bench for the RTC timestamp, prescaler and alarm unit
`timescale 1ns/10ps
`default_nettype none
`include "rtcta_regs.svh"

module rtcta_top_tb;
  logic                  sys_clk_in, rst_in, soft_rst_in, ce_in, wr_in, rd_in, cap_ev;
  logic [3:0]            addr_in;
  logic [15:0]           wr_data_in;
  logic [15:0]           rd_data_out;
  logic                  tick_out, half_tick_out, alarm_irq_out;
  rtcta_pkg::rtcta_time_t cur_t;
  int                    n_mismatch, cmp_count;
  logic [15:0]           irq_cnt;

  rtcta_top dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .soft_rst_in(soft_rst_in), .ce_in(ce_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .rd_data_out(rd_data_out), .cur_time_in(cur_t), .capture_event_in(cap_ev),
    .tick_out(tick_out), .half_tick_out(half_tick_out), .alarm_irq_out(alarm_irq_out));

  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  // Alarm pulses are one cycle wide, so count them at every edge
  always @(posedge sys_clk_in) begin
    if (rst_in) irq_cnt <= 16'h0000;
    else if (alarm_irq_out === 1'b1) irq_cnt <= irq_cnt + 16'h0001;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    wr_in <= 1'b1; addr_in <= a; wr_data_in <= d;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk_in);
    rd_in <= 1'b1; addr_in <= a;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 chk(rd_data_out, e);
  endtask : rd

  task automatic wait_tick;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (tick_out !== 1'b1 && n < 4000);
    if (n >= 4000) chk(16'h0bad, 16'h0000);
  endtask : wait_tick

  task automatic t_reset_vals;
    rd(`RTCTA_A_ALM_CTRL, 16'h0000);
    rd(`RTCTA_A_DIV, 16'hffff);
    // Read data stand for one cycle only
    @(posedge sys_clk_in);
    #1 chk(rd_data_out, 16'h0000);
    rd(`RTCTA_A_FINE_PRESCALE, 16'h001f);
    rd(`RTCTA_A_TS_DL, 16'h0000);
    rd(`RTCTA_A_TS_DH, 16'h0000);
    rd(4'hc, 16'h0000);
    $display("test reset_vals done");
  endtask : t_reset_vals

  task automatic t_storage;
    wr(`RTCTA_A_TS_TH, 16'hffff);
    wr(`RTCTA_A_TS_DH, 16'hffff);
    wr(`RTCTA_A_TS_DL, 16'hffff);
    @(posedge sys_clk_in);
    soft_rst_in <= 1'b1;
    @(posedge sys_clk_in);
    soft_rst_in <= 1'b0;
    rd(`RTCTA_A_TS_TH, 16'hffff);
    rd(`RTCTA_A_TS_DL, 16'hffff);
    wr(`RTCTA_A_CTRL, 16'h0001);
    rd(`RTCTA_A_TS_TH, 16'h3f7f);
    rd(`RTCTA_A_TS_DL, 16'h3f07);
    rd(`RTCTA_A_TS_DH, 16'hff1f);
    $display("test storage done");
  endtask : t_storage

  task automatic t_capture;
    cur_t.hours_tens <= 2'h1; cur_t.hours_units <= 4'h7;
    cur_t.minutes_tens <= 3'h4; cur_t.minutes_units <= 4'h5;
    cur_t.day_tens <= 2'h2; cur_t.day_units <= 4'h8; cur_t.weekday_digit <= 3'h3;
    cur_t.year_tens <= 4'h2; cur_t.year_units <= 4'h6;
    cur_t.month_tens <= 1'b1; cur_t.month_units <= 4'h2;
    @(posedge sys_clk_in);
    cap_ev <= 1'b1;
    @(posedge sys_clk_in);
    cap_ev <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    rd(`RTCTA_A_CTRL, 16'h0003);
    rd(`RTCTA_A_TS_TH, 16'h1745);
    rd(`RTCTA_A_TS_DL, 16'h2803);
    rd(`RTCTA_A_TS_DH, 16'h2612);
    // Event while the flag is set is ignored
    cur_t.minutes_units <= 4'h9;
    @(posedge sys_clk_in);
    cap_ev <= 1'b1;
    @(posedge sys_clk_in);
    cap_ev <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    rd(`RTCTA_A_TS_TH, 16'h1745);
    // Clear the flag, then start a capture from software
    wr(`RTCTA_A_CTRL, 16'h0001);
    wr(`RTCTA_A_CTRL, 16'h0003);
    repeat (6) @(posedge sys_clk_in);
    rd(`RTCTA_A_CTRL, 16'h0003);
    rd(`RTCTA_A_TS_TH, 16'h1749);
    wr(`RTCTA_A_CTRL, 16'h0000);
    $display("test capture done");
  endtask : t_capture

  task automatic t_period(input logic [15:0] dv, input logic [4:0] fd, input int exp);
    int n;
    wr(`RTCTA_A_DIV, dv);
    wr(`RTCTA_A_FINE_PRESCALE, {11'h000, fd});
    wait_tick();
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (tick_out !== 1'b1 && n < 4000);
    chk(16'(n), 16'(exp));
  endtask : t_period

  task automatic t_freeze;
    int n;
    wait_tick();
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (half_tick_out !== 1'b1 && n < 4000);
    chk(16'(n), 16'h0004);
    // Five frozen cycles stretch the period by five
    wait_tick();
    ce_in <= 1'b0;
    repeat (5) @(posedge sys_clk_in);
    ce_in <= 1'b1;
    n = 5;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (tick_out !== 1'b1 && n < 4000);
    chk(16'(n), 16'h000d);
    $display("test freeze done");
  endtask : t_freeze

  task automatic alarm_run(input logic [15:0] ctl, input int cyc, input logic [15:0] n,
                           input logic [15:0] e);
    logic [15:0] base;
    base = irq_cnt;
    wr(`RTCTA_A_ALM_CTRL, ctl);
    repeat (cyc) @(posedge sys_clk_in);
    chk(irq_cnt - base, n);
    rd(`RTCTA_A_ALM_CTRL, e);
  endtask : alarm_run

  task automatic t_alarm;
    logic [15:0] base;
    t_period(16'h0000, 5'h07, 8);
    t_period(16'h0000, 5'h09, 10);
    t_period(16'h0001, 5'h00, 33);
    t_period(16'h0000, 5'h07, 8);
    t_freeze();
    alarm_run(16'h8f00, 24, 0, 16'h8f00);
    alarm_run(16'h0000, 1, 0, 16'h0000);
    alarm_run(16'h8100, 48, 1, 16'h0100);
    alarm_run(16'h8102, 48, 3, 16'h0100);
    alarm_run(16'h8001, 40, 2, 16'h0000);
    alarm_run(16'h81ff, 2400, 256, 16'h0100);
    base = irq_cnt;
    wr(`RTCTA_A_ALM_CTRL, 16'hc100);
    while (irq_cnt - base < 16'h0002) @(posedge sys_clk_in);
    rd(`RTCTA_A_ALM_CTRL, 16'hc1fe);
    alarm_run(16'h0000, 24, 0, 16'h0000);
    cur_t.seconds_tens <= 3'h1; cur_t.seconds_units <= 4'h2;
    wr(`RTCTA_A_AV_TL, 16'h3400);
    alarm_run(16'h8300, 40, 0, 16'h8300);
    base = irq_cnt;
    cur_t.seconds_tens <= 3'h3; cur_t.seconds_units <= 4'h4;
    repeat (12) @(posedge sys_clk_in);
    chk(irq_cnt - base, 16'h0001);
    rd(`RTCTA_A_ALM_CTRL, 16'h0300);
    // Ten-minute interval also needs the minute units digit
    alarm_run(16'h8400, 40, 0, 16'h8400);
    alarm_run(16'h0000, 1, 0, 16'h0000);
    $display("test alarm done");
  endtask : t_alarm

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    #(40 * 20000);
    n_mismatch++;
    finish_test();
  end

  initial begin
    rst_in = 1'b1; soft_rst_in = 1'b0; ce_in = 1'b1; wr_in = 1'b0; rd_in = 1'b0;
    cap_ev = 1'b0; addr_in = 4'h0; wr_data_in = 16'h0000; cur_t = '0;
    n_mismatch = 0; cmp_count = 0;
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_reset_vals();
    t_storage();
    t_capture();
    t_alarm();
    finish_test();
  end
endmodule : rtcta_top_tb
`default_nettype wire
